// file: design/double_to_single.sv
// Double to single format conversion for float stores
module double_to_single (
    input wire logic [63:0] dbl_i,
    output logic [31:0] sgl_o
);
    logic [10:0] exp;

    assign exp = dbl_i[62:52];

    // Normal range keeps rebiased exponent; else truncated bits, denorm shifted
    always_comb begin
        if (exp > store_unit_pkg::DBL_BIAS_DIFF || exp == '0) begin
            sgl_o = {dbl_i[63:62], dbl_i[58:29]};
        end else begin
            // Tiny values are denormalised; shift right by the deficit
            sgl_o = {dbl_i[63], 8'h00,
                     23'(({1'b1, dbl_i[51:30]}) >> (store_unit_pkg::DBL_SGL_MIN_EXP - exp))};
        end
    end
endmodule : double_to_single

// file: design/fp_and_halfword_store_unit.sv
// Functional notes
// - Decode double indexed stores, with and without update.
// - Double stores write all 64 FPR bits unchanged as eight bytes.
// - Update forms write the effective address back to the base GPR.
// - Update form with base field zero is an invalid form.
// - Indexed non-update address: index plus base, base zero if field zero.
// - Indexed update address: base register plus index register always.
// - Displacement non-update: sign-extended displacement plus base or zero.
// - Displacement update: sign-extended displacement plus base register.
// - Decode optional integer-word float store, enabled by parameter.
// - Integer-word store writes low 32 FPR bits without conversion.
// - Integer-word data undefined after single-precision producers.
// - Undefined condition follows through floating-point register moves.
// - Single stores convert source to single and write four bytes.
// - Decode single displacement stores and plain half displacement store.
// - Decode single indexed stores and half indexed update store.
// - Decode half displacement store with update.
// - Half stores write low 16 bits of the source GPR.
// - Byte-reversed half store swaps bytes into memory order.
module fp_and_halfword_store_unit #(
    parameter bit INT_WORD_EN = 1'b1,
    parameter int ADDR_W = 64
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Issue side
    input wire logic issue_valid_i,
    output logic issue_ready_o,
    input wire logic [31:0] instr_i,
    input wire logic [63:0] base_gpr_i,
    input wire logic [63:0] index_gpr_i,
    input wire logic [63:0] source_gpr_i,
    input wire logic [63:0] source_fpr_i,
    input wire logic source_fpr_single_i,
    // Register read port field numbers
    output logic [4:0] base_gpr_field_o,
    output logic [4:0] index_gpr_field_o,
    output logic [4:0] source_gpr_field_o,
    output logic [4:0] source_fpr_field_o,
    // Memory write request
    output logic mem_valid_o,
    input wire logic mem_ready_i,
    output logic [ADDR_W-1:0] effective_address_o,
    output logic [63:0] mem_data_o,
    output logic [3:0] mem_size_o,
    output logic mem_data_undef_o,
    // Base register writeback
    output logic wb_valid_o,
    output logic [4:0] wb_field_o,
    output logic [ADDR_W-1:0] wb_data_o,
    // Decode outcomes
    output logic invalid_form_o,
    output logic not_store_o
);
    typedef enum logic {
        ST_IDLE,
        ST_MEM
    } state_t;

    state_t state_q;
    store_unit_pkg::store_fmt_t fmt;
    logic indexed;
    logic update;
    logic [4:0] base_field;
    logic [ADDR_W-1:0] base_val;
    logic [ADDR_W-1:0] offset;
    logic [ADDR_W-1:0] ea_d;
    logic [63:0] data_d;
    logic [3:0] size_d;
    logic [31:0] single_val;
    logic accept;
    logic invalid;

    // Field extraction from the instruction word
    assign base_field = instr_i[store_unit_pkg::BASE_HI:store_unit_pkg::BASE_LO];
    assign base_gpr_field_o = base_field;
    assign index_gpr_field_o = instr_i[store_unit_pkg::IDX_HI:store_unit_pkg::IDX_LO];
    assign source_gpr_field_o = instr_i[store_unit_pkg::SRC_HI:store_unit_pkg::SRC_LO];
    assign source_fpr_field_o = instr_i[store_unit_pkg::SRC_HI:store_unit_pkg::SRC_LO];

    store_decoder #(
        .INT_WORD_EN(INT_WORD_EN)
    ) u_dec (
        .instr_i(instr_i),
        .fmt_o(fmt),
        .indexed_o(indexed),
        .update_o(update)
    );

    double_to_single u_cvt (
        .dbl_i(source_fpr_i),
        .sgl_o(single_val)
    );

    // Sign extension used by both displacement paths
    function automatic logic [ADDR_W-1:0] sign_extend(input logic [15:0] d);
        sign_extend = {{(ADDR_W - store_unit_pkg::DISP_W){d[15]}}, d};
    endfunction : sign_extend

    // Effective address: update forms always read the base register
    always_comb begin
        if (base_field == store_unit_pkg::ZERO_REG && !update) begin
            base_val = '0;
        end else begin
            base_val = base_gpr_i[ADDR_W-1:0];
        end
        if (indexed) begin
            offset = index_gpr_i[ADDR_W-1:0];
        end else begin
            offset = sign_extend(instr_i[store_unit_pkg::DISP_HI:store_unit_pkg::DISP_LO]);
        end
        ea_d = base_val + offset;
    end

    assign invalid = update && base_field == store_unit_pkg::ZERO_REG;

    // Accepted word that raises a request; displacement for the checks below
    logic take;
    logic [15:0] disp;
    assign take = accept && fmt != store_unit_pkg::FMT_NONE && !invalid;
    assign disp = instr_i[store_unit_pkg::DISP_HI:store_unit_pkg::DISP_LO];

    // Data formatting, right-justified into the low bits of the 64-bit bus by size
    always_comb begin
        data_d = '0;
        size_d = '0;
        unique case (fmt)
            store_unit_pkg::FMT_NONE: begin
                data_d = '0;
            end
            store_unit_pkg::FMT_DOUBLE: begin
                data_d = source_fpr_i;
                size_d = store_unit_pkg::SIZE_DOUBLE;
            end
            store_unit_pkg::FMT_INT_WORD: begin
                data_d = {32'h0000_0000, source_fpr_i[31:0]};
                size_d = store_unit_pkg::SIZE_WORD;
            end
            store_unit_pkg::FMT_SINGLE: begin
                data_d = {32'h0000_0000, single_val};
                size_d = store_unit_pkg::SIZE_WORD;
            end
            store_unit_pkg::FMT_HALF: begin
                data_d = {48'h0000_0000_0000, source_gpr_i[15:0]};
                size_d = store_unit_pkg::SIZE_HALF;
            end
            // Source bits 15:8 to memory bits 0-7, lowest byte to bits 8-15
            store_unit_pkg::FMT_HALF_REV: begin
                data_d = {48'h0000_0000_0000, source_gpr_i[7:0], source_gpr_i[15:8]};
                size_d = store_unit_pkg::SIZE_HALF;
            end
        endcase
    end

    // One instruction in flight; ready only while idle
    assign issue_ready_o = state_q == ST_IDLE;
    assign accept = clk_en_i && issue_valid_i && issue_ready_o;

    // Sequencing: hold the request until memory accepts it
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else if (clk_en_i) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept && fmt != store_unit_pkg::FMT_NONE && !invalid) begin
                        state_q <= ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (mem_ready_i) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Request payload captured at accept
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            effective_address_o <= '0;
            mem_data_o <= '0;
            mem_size_o <= '0;
            mem_data_undef_o <= 1'b0;
            wb_field_o <= '0;
            wb_data_o <= '0;
        end else if (accept) begin
            effective_address_o <= ea_d;
            mem_data_o <= data_d;
            mem_size_o <= size_d;
            mem_data_undef_o <= fmt == store_unit_pkg::FMT_INT_WORD && source_fpr_single_i;
            wb_field_o <= base_field;
            wb_data_o <= ea_d;
        end
    end

    // Update flag rides with the memory request
    logic upd_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            upd_q <= 1'b0;
        end else if (accept) begin
            upd_q <= update;
        end
    end

    // Decode outcome pulses, one cycle after issue
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            invalid_form_o <= 1'b0;
            not_store_o <= 1'b0;
        end else if (clk_en_i) begin
            invalid_form_o <= accept && fmt != store_unit_pkg::FMT_NONE && invalid;
            not_store_o <= accept && fmt == store_unit_pkg::FMT_NONE;
        end
    end

    assign mem_valid_o = state_q == ST_MEM;
    assign wb_valid_o = mem_valid_o && mem_ready_i && clk_en_i && upd_q;

    wb_with_mem_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wb_valid_o |-> mem_valid_o && mem_ready_i) else $error("writeback without store");

    wb_addr_match_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wb_valid_o |-> wb_data_o == effective_address_o) else $error("writeback address wrong");

    invalid_no_store_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        invalid_form_o |-> !mem_valid_o) else $error("invalid form issued store");

    zero_base_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && update && fmt != store_unit_pkg::FMT_NONE && base_field == '0
        |=> invalid_form_o) else $error("invalid form missed");

    double_size_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && fmt == store_unit_pkg::FMT_DOUBLE && !invalid
        |=> mem_valid_o && mem_size_o == store_unit_pkg::SIZE_DOUBLE
            && mem_data_o == $past(source_fpr_i)) else $error("double store data wrong");

    half_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && fmt == store_unit_pkg::FMT_HALF && !invalid
        |=> mem_data_o[15:0] == $past(source_gpr_i[15:0])
            && mem_size_o == store_unit_pkg::SIZE_HALF) else $error("half store data wrong");

    half_rev_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && fmt == store_unit_pkg::FMT_HALF_REV
        |=> mem_data_o[15:8] == $past(source_gpr_i[7:0])) else $error("byte reversal wrong");

    zero_base_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && indexed && !update && base_field == '0 && fmt != store_unit_pkg::FMT_NONE
        |=> effective_address_o == $past(index_gpr_i[ADDR_W-1:0])) else $error("zero base ea wrong");

    int_word_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && fmt == store_unit_pkg::FMT_INT_WORD
        |=> mem_data_o[31:0] == $past(source_fpr_i[31:0])
            && mem_size_o == store_unit_pkg::SIZE_WORD) else $error("integer word data wrong");

    req_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(effective_address_o))
        else $error("request dropped");

    idx_base_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && indexed && !update && base_field != '0 |=> effective_address_o ==
        $past(base_gpr_i[ADDR_W-1:0] + index_gpr_i[ADDR_W-1:0])) else $error("idx ea wrong");

    idx_upd_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && indexed && update |=> effective_address_o ==
        $past(base_gpr_i[ADDR_W-1:0] + index_gpr_i[ADDR_W-1:0])) else $error("idx upd ea wrong");

    disp_base_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && !indexed && !update && base_field != '0 |=> effective_address_o ==
        $past(base_gpr_i[ADDR_W-1:0] + ADDR_W'($signed(disp)))) else $error("disp ea wrong");

    disp_zero_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && !indexed && !update && base_field == '0 |=> effective_address_o ==
        $past(ADDR_W'($signed(disp)))) else $error("zero disp ea wrong");

    disp_upd_ea_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && !indexed && update |=> effective_address_o ==
        $past(base_gpr_i[ADDR_W-1:0] + ADDR_W'($signed(disp)))) else $error("disp upd ea wrong");

    single_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && fmt == store_unit_pkg::FMT_SINGLE |=> mem_size_o == store_unit_pkg::SIZE_WORD
            && mem_data_o[63:31] == {32'h0000_0000, $past(source_fpr_i[63])})
        else $error("single store wrong");

    undef_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take |=> mem_data_undef_o == ($past(fmt == store_unit_pkg::FMT_INT_WORD)
            && $past(source_fpr_single_i))) else $error("undefined flag wrong");

    wb_field_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && update |=> wb_field_o == $past(base_field) && wb_field_o != '0)
        else $error("writeback field wrong");

    idle_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        issue_ready_o |-> !mem_valid_o && !wb_valid_o) else $error("idle unit wrote");

    not_store_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && fmt == store_unit_pkg::FMT_NONE |=> not_store_o && !mem_valid_o)
        else $error("unknown word not refused");

    done_ready_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mem_valid_o && mem_ready_i && clk_en_i |=> issue_ready_o && !mem_valid_o)
        else $error("request not retired");

    rev_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        take && fmt == store_unit_pkg::FMT_HALF_REV |=> mem_data_o[7:0] ==
        $past(source_gpr_i[15:8]) && mem_size_o == store_unit_pkg::SIZE_HALF)
        else $error("reversed low byte wrong");
endmodule : fp_and_halfword_store_unit

// file: design/store_decoder.sv
// Pure decode of one instruction word into store attributes
module store_decoder #(
    parameter bit INT_WORD_EN = 1'b1
) (
    input wire logic [31:0] instr_i,
    output store_unit_pkg::store_fmt_t fmt_o,
    output logic indexed_o,
    output logic update_o
);
    logic [5:0] opcd;
    logic [9:0] xo;

    assign opcd = instr_i[store_unit_pkg::OPCD_HI:store_unit_pkg::OPCD_LO];
    assign xo = instr_i[store_unit_pkg::XO_HI:store_unit_pkg::XO_LO];

    // Table decode; anything unknown yields no store
    always_comb begin
        fmt_o = store_unit_pkg::FMT_NONE;
        indexed_o = 1'b0;
        update_o = 1'b0;
        if (opcd == store_unit_pkg::OP_SINGLE_D) begin
            fmt_o = store_unit_pkg::FMT_SINGLE;
        end else if (opcd == store_unit_pkg::OP_SINGLE_DU) begin
            fmt_o = store_unit_pkg::FMT_SINGLE;
            update_o = 1'b1;
        end else if (opcd == store_unit_pkg::OP_HALF_D) begin
            fmt_o = store_unit_pkg::FMT_HALF;
        end else if (opcd == store_unit_pkg::OP_HALF_DU) begin
            fmt_o = store_unit_pkg::FMT_HALF;
            update_o = 1'b1;
        end else if (opcd == store_unit_pkg::OP_EXT && !instr_i[0]) begin
            indexed_o = 1'b1;
            if (xo == store_unit_pkg::XO_DOUBLE_XU) begin
                fmt_o = store_unit_pkg::FMT_DOUBLE;
                update_o = 1'b1;
            end else if (xo == store_unit_pkg::XO_DOUBLE_X) begin
                fmt_o = store_unit_pkg::FMT_DOUBLE;
            end else if (xo == store_unit_pkg::XO_INTWORD_X && INT_WORD_EN) begin
                fmt_o = store_unit_pkg::FMT_INT_WORD;
            end else if (xo == store_unit_pkg::XO_SINGLE_XU) begin
                fmt_o = store_unit_pkg::FMT_SINGLE;
                update_o = 1'b1;
            end else if (xo == store_unit_pkg::XO_SINGLE_X) begin
                fmt_o = store_unit_pkg::FMT_SINGLE;
            end else if (xo == store_unit_pkg::XO_HALF_XU) begin
                fmt_o = store_unit_pkg::FMT_HALF;
                update_o = 1'b1;
            end else if (xo == store_unit_pkg::XO_HALF_BR_X) begin
                fmt_o = store_unit_pkg::FMT_HALF_REV;
            end else begin
                indexed_o = 1'b0;
            end
        end
    end
endmodule : store_decoder

// file: design/store_unit_pkg.sv
package store_unit_pkg;
    // Primary opcode field, instruction bits 0..5 (MSB numbering)
    localparam int OPCD_HI = 31;
    localparam int OPCD_LO = 26;
    localparam int SRC_HI = 25;
    localparam int SRC_LO = 21;
    localparam int BASE_HI = 20;
    localparam int BASE_LO = 16;
    localparam int IDX_HI = 15;
    localparam int IDX_LO = 11;
    localparam int XO_HI = 10;
    localparam int XO_LO = 1;
    localparam int DISP_HI = 15;
    localparam int DISP_LO = 0;
    localparam int DISP_W = 16;
    localparam int REG_IDX_W = 5;

    // Primary opcodes
    localparam logic [5:0] OP_EXT = 6'h1F;
    localparam logic [5:0] OP_SINGLE_D = 6'h34;
    localparam logic [5:0] OP_SINGLE_DU = 6'h35;
    localparam logic [5:0] OP_HALF_D = 6'h2C;
    localparam logic [5:0] OP_HALF_DU = 6'h2D;

    // Extended opcodes of the indexed forms
    localparam logic [9:0] XO_DOUBLE_XU = 10'h2F7;
    localparam logic [9:0] XO_DOUBLE_X = 10'h2D7;
    localparam logic [9:0] XO_INTWORD_X = 10'h3D7;
    localparam logic [9:0] XO_SINGLE_XU = 10'h2B7;
    localparam logic [9:0] XO_SINGLE_X = 10'h297;
    localparam logic [9:0] XO_HALF_XU = 10'h1B7;
    localparam logic [9:0] XO_HALF_BR_X = 10'h396;

    // Zero register field selects the literal zero base
    localparam logic [4:0] ZERO_REG = 5'h00;

    // Memory store sizes in bytes
    localparam logic [3:0] SIZE_DOUBLE = 4'h8;
    localparam logic [3:0] SIZE_WORD = 4'h4;
    localparam logic [3:0] SIZE_HALF = 4'h2;

    // Double and single float layout
    localparam int DBL_EXP_W = 11;
    localparam int SGL_EXP_W = 8;
    localparam logic [10:0] DBL_BIAS_DIFF = 11'h380;
    localparam logic [10:0] DBL_SGL_MIN_EXP = 11'h381;
    localparam logic [10:0] DBL_SGL_MAX_EXP = 11'h47E;

    // Kinds of store data formatting
    typedef enum logic [2:0] {
        FMT_NONE,
        FMT_DOUBLE,
        FMT_INT_WORD,
        FMT_SINGLE,
        FMT_HALF,
        FMT_HALF_REV
    } store_fmt_t;
endpackage : store_unit_pkg

// file: verification/mem_model.sv
// Memory side of the store path: accepts one request at a time
module mem_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic mem_valid_i,
    input wire logic slow_i,
    output logic mem_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] wait_q;

    // Ready after one cycle, or after a stall when slow; dropped after each handshake
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mem_ready_o <= 1'b0;
            wait_q <= 2'h0;
        end else if (clk_en_i) begin
            if (mem_valid_i && mem_ready_o) begin
                mem_ready_o <= 1'b0;
                wait_q <= 2'h0;
            end else if (mem_valid_i && (!slow_i || wait_q == 2'h3)) begin
                mem_ready_o <= 1'b1;
            end else if (mem_valid_i) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule : mem_model

// file: verification/tb.sv
// Self-checking bench for the float and half-word store unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] TMPL [0:10] = '{32'h7C0005EE, 32'h7C0005AE, 32'h7C0007AE,
        32'hD0000000, 32'hD4000000, 32'hB0000000, 32'hB4000000, 32'h7C00056E,
        32'h7C00052E, 32'h7C00036E, 32'h7C00072C};
    // Kinds: 0 double, 1 integer word, 2 single, 3 half, 4 reversed half
    localparam int KIND [0:10] = '{0, 0, 1, 2, 2, 3, 3, 2, 2, 3, 4};

    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic issue_valid_i = 1'b0;
    logic source_fpr_single_i = 1'b0;
    logic slow = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [63:0] base_gpr_i = 64'h0;
    logic [63:0] index_gpr_i = 64'h0;
    logic [63:0] source_gpr_i = 64'h0;
    logic [63:0] source_fpr_i = 64'h0;
    logic issue_ready_o, mem_valid_o, mem_ready_i, mem_data_undef_o, wb_valid_o;
    logic invalid_form_o, not_store_o;
    logic [4:0] base_gpr_field_o, index_gpr_field_o, source_gpr_field_o, source_fpr_field_o;
    logic [4:0] wb_field_o;
    logic [63:0] effective_address_o, mem_data_o, wb_data_o;
    logic [3:0] mem_size_o;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    integer seed = 32'h3C8E6A1D;

    always #4 clock_i = ~clock_i;

    fp_and_halfword_store_unit u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i), .issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o),
        .instr_i(instr_i), .base_gpr_i(base_gpr_i), .index_gpr_i(index_gpr_i),
        .source_gpr_i(source_gpr_i), .source_fpr_i(source_fpr_i),
        .source_fpr_single_i(source_fpr_single_i), .base_gpr_field_o(base_gpr_field_o),
        .index_gpr_field_o(index_gpr_field_o), .source_gpr_field_o(source_gpr_field_o),
        .source_fpr_field_o(source_fpr_field_o), .mem_valid_o(mem_valid_o),
        .mem_ready_i(mem_ready_i), .effective_address_o(effective_address_o),
        .mem_data_o(mem_data_o), .mem_size_o(mem_size_o), .mem_data_undef_o(mem_data_undef_o),
        .wb_valid_o(wb_valid_o), .wb_field_o(wb_field_o), .wb_data_o(wb_data_o),
        .invalid_form_o(invalid_form_o), .not_store_o(not_store_o));

    mem_model u_mem (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .mem_valid_i(mem_valid_o), .slow_i(slow), .mem_ready_o(mem_ready_i));

    task automatic final_report();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic is_upd(input logic [31:0] w);
        return (w[31:26] == 6'h1F) ? w[6] : w[26];
    endfunction : is_upd

    // Single image: rebias when normal, denormalise when tiny
    function automatic logic [31:0] to_single(input logic [63:0] f);
        logic [22:0] m;
        m = {1'b1, f[51:30]} >> (11'h381 - f[62:52]);
        return (f[62:52] > 11'h380) ? {f[63:62], f[58:29]} : {f[63], 8'h00, m};
    endfunction : to_single

    // Offer one word at a falling edge, taken at the next rising edge
    task automatic issue(input logic [31:0] w);
        int n;
        n = 0;
        while (issue_ready_o !== 1'b1 && n < 50) begin
            @(negedge clock_i);
            n++;
        end
        instr_i = w;
        issue_valid_i = 1'b1;
        #1;
        chk("fields", {w[20:16], w[15:11], w[25:21], w[25:21]}, {base_gpr_field_o,
            index_gpr_field_o, source_gpr_field_o, source_fpr_field_o});
        @(negedge clock_i);
        issue_valid_i = 1'b0;
        // Operands scrambled after accept so stale capture shows up
        instr_i = ~w;
        base_gpr_i = ~base_gpr_i;
        index_gpr_i = ~index_gpr_i;
        source_gpr_i = ~source_gpr_i;
        source_fpr_i = ~source_fpr_i;
    endtask : issue

    task automatic do_store(input int k, input logic [4:0] bf, input logic [15:0] d,
                            input logic frz);
        logic [31:0] w;
        logic upd, idx, tag;
        logic [63:0] b, x, g, f, ea, dat;
        logic [3:0] sz;
        int n;
        w = TMPL[k];
        w[25:21] = 5'($random(seed));
        w[20:16] = bf;
        idx = (w[31:26] == 6'h1F);
        upd = is_upd(w);
        if (idx) w[15:11] = 5'($random(seed));
        else w[15:0] = d;
        b = {$random(seed), $random(seed)};
        x = {$random(seed), $random(seed)};
        g = {$random(seed), $random(seed)};
        f = {$random(seed), $random(seed)};
        tag = 1'($random(seed));
        if (KIND[k] == 2) f[62:52] = 11'h37A + {7'h00, f[3:0]};
        ea = ((upd || bf != 5'h0) ? b : 64'h0) + (idx ? x : {{48{d[15]}}, d});
        case (KIND[k])
            0: begin dat = f; sz = 4'h8; end
            1: begin dat = {32'h0, f[31:0]}; sz = 4'h4; end
            2: begin dat = {32'h0, to_single(f)}; sz = 4'h4; end
            3: begin dat = {48'h0, g[15:0]}; sz = 4'h2; end
            default: begin dat = {48'h0, g[7:0], g[15:8]}; sz = 4'h2; end
        endcase
        base_gpr_i = b;
        index_gpr_i = x;
        source_gpr_i = g;
        source_fpr_i = f;
        source_fpr_single_i = tag;
        slow = 1'($random(seed));
        issue(w);
        chk("accept", 2'b01, {issue_ready_o, mem_valid_o});
        if (frz) begin
            clk_en_i = 1'b0;
            repeat (2) begin
                @(negedge clock_i);
                chk("frozen", 2'b01, {wb_valid_o, mem_valid_o});
            end
            clk_en_i = 1'b1;
        end
        n = 0;
        while (!(mem_valid_o === 1'b1 && mem_ready_i === 1'b1) && n < 20) begin
            @(negedge clock_i);
            n++;
        end
        chk("address", ea, effective_address_o);
        chk("data", dat, mem_data_o);
        chk("size", {60'h0, sz}, {60'h0, mem_size_o});
        chk("undef", KIND[k] == 1 && tag, mem_data_undef_o);
        chk("wb_valid", upd, wb_valid_o);
        if (upd) begin
            chk("wb_field", bf, wb_field_o);
            chk("wb_data", ea, wb_data_o);
        end
        @(negedge clock_i);
        chk("done", 2'b10, {issue_ready_o, mem_valid_o});
    endtask : do_store

    // Refused words: expected pulses as invalid, not a store, no request
    task automatic bad_word(input logic [31:0] w, input logic [2:0] exp);
        issue(w);
        chk("refused", exp, {invalid_form_o, not_store_o, mem_valid_o});
        @(negedge clock_i);
        chk("pulse_end", 3'b000, {invalid_form_o, not_store_o, mem_valid_o});
    endtask : bad_word

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        int i;
        int k;
        logic [4:0] bf;
        logic [15:0] d;
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk("reset", 5'b10000, {issue_ready_o, mem_valid_o, wb_valid_o, invalid_form_o,
            not_store_o});
        // First pass zero base field on non-update forms, first two passes extreme offsets, then random
        for (i = 0; i < 132; i++) begin
            k = i % 11;
            bf = (i < 11) ? 5'h00 : 5'($random(seed));
            if (is_upd(TMPL[k]) && bf == 5'h00) bf = 5'h1F;
            d = (i < 11) ? 16'h8000 : (i < 22) ? 16'h7FFF : 16'($random(seed));
            do_store(k, bf, d, i % 13 == 5);
        end
        // Update forms with base field zero
        for (k = 0; k < 11; k++) begin
            if (is_upd(TMPL[k])) bad_word(TMPL[k], 3'b100);
        end
        bad_word(32'h90000000, 3'b010);
        bad_word(32'h7C00052C, 3'b010);
        bad_word(32'h7C0005AF, 3'b010);
        final_report();
    end
endmodule : tb
